// >>> logic/bds_pkg.sv
package bds_pkg;

	// ----------------------------------------------------------------
	// Organisation
	// ----------------------------------------------------------------
	localparam int DATA_W     = 36;
	localparam int LANE_W     = 9;
	localparam int LANES      = 4;
	localparam int LANES_X18  = 2;
	localparam int ADDR_W     = 8;
	localparam int MEM_DEPTH  = 256;
	localparam int BURST_LEN  = 4;
	localparam int FIFO_DEPTH = 4;

	// ----------------------------------------------------------------
	// Timing, in K cycles and in system cycles (one K edge per cycle)
	// ----------------------------------------------------------------
	localparam int EDGES_PER_K    = 2;
	localparam int RD_LATENCY_K   = 2;
	localparam int RD_LATENCY_SYS = RD_LATENCY_K * EDGES_PER_K;
	localparam int WR_DELAY_K     = 1;
	localparam int WR_DELAY_SYS   = WR_DELAY_K * EDGES_PER_K;

	// Schedule shift registers: bit k is high k+1 cycles after a start
	localparam int RD_SCHED_W   = 7;
	localparam int RD_POP_FIRST = RD_LATENCY_SYS - 2;
	localparam int RD_POP_LAST  = RD_POP_FIRST + BURST_LEN - 1;
	localparam int WR_SCHED_W   = 5;
	localparam int WR_COPY_TAP  = 0;
	localparam int WR_CAP_FIRST = WR_DELAY_SYS - 1;
	localparam int WR_CAP_LAST  = WR_CAP_FIRST + BURST_LEN - 1;

	// ----------------------------------------------------------------
	// Reset and load values
	// ----------------------------------------------------------------
	localparam logic             PHASE_RST = 1'b0;
	localparam logic [2:0]       LEFT_RST  = 3'h0;
	localparam logic [2:0]       LEFT_LOAD = 3'h4;
	localparam logic [DATA_W-1:0] WORD_RST = 36'h0;

	typedef logic [DATA_W-1:0] bds_word_t;
	typedef logic [ADDR_W-1:0] bds_addr_t;

	typedef struct packed {
		logic      read_port_select_n;
		logic      write_port_select_n;
		bds_addr_t addr;
	} bds_cmd_s;

	typedef struct packed {
		logic [LANES-1:0] byte_write_select_n;
		bds_word_t        data;
	} bds_wdata_s;

endpackage : bds_pkg

// >>> logic/bds_fifo.sv
`timescale 1ns/1ps
module bds_fifo #(
	parameter int W     = 36,
	parameter int DEPTH = 4
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	input  wire logic [W-1:0] in_data_in,
	output logic              out_valid_out,
	input  wire logic         out_ready_in,
	output logic [W-1:0]      out_data_out
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [W-1:0]     mem_r [DEPTH];
	logic [PTR_W-1:0] wr_ptr_r;
	logic [PTR_W-1:0] wr_ptr_nxt;
	logic [PTR_W-1:0] rd_ptr_r;
	logic [PTR_W-1:0] rd_ptr_nxt;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;
	logic             push;
	logic             pop;

	assign in_ready_out  = (count_r != CNT_W'(DEPTH));
	assign out_valid_out = (count_r != '0);
	assign out_data_out  = mem_r[rd_ptr_r];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	always_comb begin
		wr_ptr_nxt = wr_ptr_r;
		rd_ptr_nxt = rd_ptr_r;
		if (push) begin
			wr_ptr_nxt = (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + PTR_W'(1);
		end
		if (pop) begin
			rd_ptr_nxt = (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + PTR_W'(1);
		end
		count_nxt = count_r + CNT_W'(push) - CNT_W'(pop);
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r  <= count_nxt;
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_in;
		end
	end

endmodule : bds_fifo

// >>> logic/bds_sram_port.sv
`timescale 1ns/1ps
// Function
// - Low read select at K rise latches address; first word out two K cycles later.
// - Read words A,A+1 on K and K# of t+2; A+2,A+3 on t+3.
// - Write words A,A+1 taken in t+1, A+2,A+3 in t+2, each captured.
// - Burst uses latched address A, then A+1, A+2, A+3.
// - Second read or write on consecutive K rises is ignored.
// - A select that started an operation last rise is don't-care now.
// - After reset both ports idle and data outputs not driven.
// - In x18 mode, select 0 writes bits 8:0, select 1 bits 17:9.
// - In x18 mode both selects high writes nothing for that word.
// - In x36 mode all four selects low writes all 36 bits.
// - In x36 mode only select 0 low writes bits 8:0 only.
// - Selects 1,2,3 enable bits 17:9, 26:18, 35:27 individually.
// - In x36 mode all selects high writes nothing for that word.
// - Byte selects sampled with every data word, may change within a burst.
module bds_sram_port (
	input  wire logic                clk_sys_in,
	input  wire logic                sys_rst_in,
	input  wire logic                org_x18_in,
	input  wire bds_pkg::bds_cmd_s   cmd_in,
	input  wire bds_pkg::bds_wdata_s wr_in,
	output logic [35:0]              dq_out,
	output logic                     dq_oe_out,
	output logic                     k_phase_out
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	bds_pkg::bds_word_t               mem_r [bds_pkg::MEM_DEPTH];
	logic                             phase_r;
	logic                             phase_nxt;
	logic                             rd_prev_r;
	logic                             rd_prev_nxt;
	logic                             wr_prev_r;
	logic                             wr_prev_nxt;
	logic [bds_pkg::RD_SCHED_W-1:0]   rd_sched_r;
	logic [bds_pkg::RD_SCHED_W-1:0]   rd_sched_nxt;
	logic [bds_pkg::WR_SCHED_W-1:0]   wr_sched_r;
	logic [bds_pkg::WR_SCHED_W-1:0]   wr_sched_nxt;
	bds_pkg::bds_addr_t               rd_addr_r;
	bds_pkg::bds_addr_t               rd_addr_nxt;
	logic [2:0]                       rd_left_r;
	logic [2:0]                       rd_left_nxt;
	bds_pkg::bds_addr_t               wr_base_r;
	bds_pkg::bds_addr_t               wr_base_nxt;
	bds_pkg::bds_addr_t               wr_cap_addr_r;
	bds_pkg::bds_addr_t               wr_cap_addr_nxt;
	bds_pkg::bds_word_t               dq_r;
	bds_pkg::bds_word_t               dq_nxt;
	logic                             dq_oe_r;
	logic                             dq_oe_nxt;

	// ----------------------------------------------------------------
	// Combinational terms
	// ----------------------------------------------------------------
	logic                             k_rise;
	logic                             rd_start;
	logic                             wr_start;
	logic                             wr_cap;
	logic                             wr_copy;
	logic                             rd_push;
	logic                             pop_slot;
	logic                             fifo_in_ready;
	logic                             fifo_out_valid;
	bds_pkg::bds_word_t               fifo_out_data;
	logic [bds_pkg::LANES-1:0]        lane_we;
	bds_pkg::bds_word_t               wr_old_word;
	bds_pkg::bds_word_t               wr_word_nxt;

	assign k_phase_out = phase_r;
	assign dq_out      = dq_r;
	assign dq_oe_out   = dq_oe_r;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// One system cycle per K edge: phase low is the K rise, high the K# rise
	assign k_rise   = (phase_r == bds_pkg::PHASE_RST);
	assign rd_start = k_rise && !cmd_in.read_port_select_n && !rd_prev_r;
	assign wr_start = k_rise && !cmd_in.write_port_select_n && !wr_prev_r;
	assign wr_copy  = wr_sched_r[bds_pkg::WR_COPY_TAP];
	assign wr_cap   = |wr_sched_r[bds_pkg::WR_CAP_LAST:bds_pkg::WR_CAP_FIRST];
	assign pop_slot = |rd_sched_r[bds_pkg::RD_POP_LAST:bds_pkg::RD_POP_FIRST];
	assign rd_push  = (rd_left_r != bds_pkg::LEFT_RST) && fifo_in_ready;

	always_comb begin
		phase_nxt    = !phase_r;
		rd_prev_nxt  = k_rise ? rd_start : rd_prev_r;
		wr_prev_nxt  = k_rise ? wr_start : wr_prev_r;
		rd_sched_nxt = {rd_sched_r[bds_pkg::RD_SCHED_W-2:0], rd_start};
		wr_sched_nxt = {wr_sched_r[bds_pkg::WR_SCHED_W-2:0], wr_start};
		wr_base_nxt  = wr_start ? cmd_in.addr : wr_base_r;
	end

	// ----------------------------------------------------------------
	// Read fetch and output
	// ----------------------------------------------------------------
	// Words are fetched ahead into the FIFO; a stalled FIFO holds the fetch
	always_comb begin
		rd_addr_nxt = rd_addr_r;
		rd_left_nxt = rd_left_r;
		if (rd_start) begin
			rd_addr_nxt = cmd_in.addr;
			rd_left_nxt = bds_pkg::LEFT_LOAD;
		end else if (rd_push) begin
			rd_addr_nxt = rd_addr_r + bds_pkg::ADDR_W'(1);
			rd_left_nxt = rd_left_r - 3'h1;
		end
	end

	bds_fifo #(
		.W     (bds_pkg::DATA_W),
		.DEPTH (bds_pkg::FIFO_DEPTH)
	) u_rd_fifo (
		.clk_in        (clk_sys_in),
		.rst_in        (sys_rst_in),
		.in_valid_in   (rd_left_r != bds_pkg::LEFT_RST),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (mem_r[rd_addr_r]),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (pop_slot),
		.out_data_out  (fifo_out_data)
	);

	always_comb begin
		dq_oe_nxt = pop_slot && fifo_out_valid;
		dq_nxt    = dq_oe_nxt ? fifo_out_data : bds_pkg::WORD_RST;
	end

	// ----------------------------------------------------------------
	// Write capture with byte lanes
	// ----------------------------------------------------------------
	always_comb begin
		wr_cap_addr_nxt = wr_cap_addr_r;
		if (wr_copy) begin
			wr_cap_addr_nxt = wr_base_r;
		end else if (wr_cap) begin
			wr_cap_addr_nxt = wr_cap_addr_r + bds_pkg::ADDR_W'(1);
		end
	end

	assign wr_old_word = mem_r[wr_cap_addr_r];

	// Lanes are decided per word from the selects seen in that very cycle
	always_comb begin
		wr_word_nxt = wr_old_word;
		for (int i = 0; i < bds_pkg::LANES; i++) begin
			lane_we[i] = wr_cap && !wr_in.byte_write_select_n[i]
				&& ((i < bds_pkg::LANES_X18) || !org_x18_in);
			if (lane_we[i]) begin
				wr_word_nxt[i*bds_pkg::LANE_W +: bds_pkg::LANE_W] =
					wr_in.data[i*bds_pkg::LANE_W +: bds_pkg::LANE_W];
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			phase_r       <= bds_pkg::PHASE_RST;
			rd_prev_r     <= 1'b0;
			wr_prev_r     <= 1'b0;
			rd_sched_r    <= '0;
			wr_sched_r    <= '0;
			rd_addr_r     <= '0;
			rd_left_r     <= bds_pkg::LEFT_RST;
			wr_base_r     <= '0;
			wr_cap_addr_r <= '0;
			dq_r          <= bds_pkg::WORD_RST;
			dq_oe_r       <= 1'b0;
		end else begin
			phase_r       <= phase_nxt;
			rd_prev_r     <= rd_prev_nxt;
			wr_prev_r     <= wr_prev_nxt;
			rd_sched_r    <= rd_sched_nxt;
			wr_sched_r    <= wr_sched_nxt;
			rd_addr_r     <= rd_addr_nxt;
			rd_left_r     <= rd_left_nxt;
			wr_base_r     <= wr_base_nxt;
			wr_cap_addr_r <= wr_cap_addr_nxt;
			dq_r          <= dq_nxt;
			dq_oe_r       <= dq_oe_nxt;
		end
	end

	// Array is cleared by reset so contents are defined from the start
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			for (int j = 0; j < bds_pkg::MEM_DEPTH; j++) begin
				mem_r[j] <= bds_pkg::WORD_RST;
			end
		end else if (wr_cap) begin
			mem_r[wr_cap_addr_r] <= wr_word_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);

	// Only a read with nothing in flight: earlier bursts may still own the outputs
	property p_rd_latency;
		(rd_start && rd_sched_r == '0) |-> !dq_oe_out [*4] ##1 dq_oe_out [*4];
	endproperty
	a_rd_latency: assert property (p_rd_latency) else $error("read data not at latency");

	property p_rd_phase;
		rd_start |-> ##4 (dq_oe_out && !k_phase_out) ##1 (dq_oe_out && k_phase_out)
			##1 (dq_oe_out && !k_phase_out) ##1 (dq_oe_out && k_phase_out);
	endproperty
	a_rd_phase: assert property (p_rd_phase) else $error("read words on wrong edges");

	property p_rd_word;
		(rd_start && rd_left_r == bds_pkg::LEFT_RST) |=>
			##3 (dq_out == $past(mem_r[rd_addr_r], 3));
	endproperty
	a_rd_word: assert property (p_rd_word) else $error("first read word wrong");

	property p_fetch_seq;
		(rd_push && !rd_start && rd_left_r > 3'h1) |=> rd_addr_r == $past(rd_addr_r) + 8'h01;
	endproperty
	a_fetch_seq: assert property (p_fetch_seq) else $error("burst address not sequential");

	property p_wr_capture;
		wr_start |-> ##2 wr_cap [*4] ##1 (wr_cap == 1'b0 || $past(wr_start, 2));
	endproperty
	a_wr_capture: assert property (p_wr_capture) else $error("write data window wrong");

	property p_rd_spacing;
		rd_start |-> ##2 !rd_start;
	endproperty
	a_rd_spacing: assert property (p_rd_spacing) else $error("back to back read taken");

	property p_wr_spacing;
		wr_start |-> ##2 !wr_start;
	endproperty
	a_wr_spacing: assert property (p_wr_spacing) else $error("back to back write taken");

	property p_dont_care;
		(k_rise && $past(rd_start, 2)) |-> !rd_start;
	endproperty
	a_dont_care: assert property (p_dont_care) else $error("select not ignored");

	property p_reset_hiz;
		$fell(sys_rst_in) |-> !dq_oe_out && !wr_cap;
	endproperty
	a_reset_hiz: assert property (p_reset_hiz) else $error("outputs driven after reset");

	property p_idle_hiz;
		(rd_sched_r == '0 && !rd_start) |=> !dq_oe_out && dq_out == bds_pkg::WORD_RST;
	endproperty
	a_idle_hiz: assert property (p_idle_hiz) else $error("outputs driven while idle");

	property p_lane0;
		(wr_cap && wr_in.byte_write_select_n[0]) |=>
			mem_r[$past(wr_cap_addr_r)][8:0] == $past(wr_old_word[8:0]);
	endproperty
	a_lane0: assert property (p_lane0) else $error("lane 0 altered");

	property p_x18_upper;
		(wr_cap && org_x18_in) |=>
			mem_r[$past(wr_cap_addr_r)][35:18] == $past(wr_old_word[35:18]);
	endproperty
	a_x18_upper: assert property (p_x18_upper) else $error("x18 upper lanes altered");

	property p_x18_none;
		(wr_cap && org_x18_in && wr_in.byte_write_select_n[1:0] == 2'h3) |=>
			mem_r[$past(wr_cap_addr_r)] == $past(wr_old_word);
	endproperty
	a_x18_none: assert property (p_x18_none) else $error("x18 masked word written");

	property p_x36_all;
		(wr_cap && !org_x18_in && wr_in.byte_write_select_n == 4'h0) |=>
			mem_r[$past(wr_cap_addr_r)] == $past(wr_in.data);
	endproperty
	a_x36_all: assert property (p_x36_all) else $error("full word not written");

	property p_lane3;
		(wr_cap && !org_x18_in && !wr_in.byte_write_select_n[3]) |=>
			mem_r[$past(wr_cap_addr_r)][35:27] == $past(wr_in.data[35:27]);
	endproperty
	a_lane3: assert property (p_lane3) else $error("lane 3 not written");

	property p_x36_none;
		(wr_cap && wr_in.byte_write_select_n == 4'hf) |=>
			mem_r[$past(wr_cap_addr_r)] == $past(wr_old_word);
	endproperty
	a_x36_none: assert property (p_x36_none) else $error("masked word written");

	c_read: cover property (rd_start ##4 dq_oe_out [*4]);
	c_write: cover property (wr_start ##2 wr_cap [*4]);
	c_read_write: cover property (rd_start && wr_start);
	c_mixed_mask: cover property (wr_cap && wr_in.byte_write_select_n == 4'h0
		##1 wr_cap && wr_in.byte_write_select_n == 4'hf);

endmodule : bds_sram_port

// >>> tb/bds_ctrl_model.sv
`timescale 1ns/1ps
module bds_ctrl_model (
	input  wire logic           clk_in,
	output bds_pkg::bds_cmd_s   cmd_out,
	output bds_pkg::bds_wdata_s wr_out
);
	localparam int SLOTS = 40;

	bds_pkg::bds_cmd_s   cmd_q [SLOTS];
	bds_pkg::bds_wdata_s wd_q  [SLOTS];
	logic                wd_v  [SLOTS];
	logic                running = 1'b0;
	int                  slot    = 0;

	initial begin
		cmd_out = '{1'b1, 1'b1, 8'h00};
		wr_out  = '0;
		clear();
	end

	task automatic clear();
		for (int i = 0; i < SLOTS; i++) begin
			cmd_q[i] = '{1'b1, 1'b1, 8'h00};
			wd_v[i]  = 1'b0;
		end
	endtask : clear

	task automatic post_cmd(input int s, input logic rd, input logic [7:0] a);
		if (rd) cmd_q[s].read_port_select_n = 1'b0;
		else cmd_q[s].write_port_select_n = 1'b0;
		cmd_q[s].addr = a;
	endtask : post_cmd

	// Lane selects travel with each word and may differ within a burst
	task automatic post_wd(input int s, input logic [3:0] m, input logic [35:0] d);
		wd_q[s] = '{m, d};
		wd_v[s] = 1'b1;
	endtask : post_wd

	// ----------------------------------------------------------------
	// Slot driver
	// ----------------------------------------------------------------
	// Released address, data and byte select lines never keep their last value, so a design that
	// samples outside its window picks up changing garbage
	always @(negedge clk_in) begin : drive
		bds_pkg::bds_cmd_s c;
		c = '{1'b1, 1'b1, ~cmd_out.addr};
		if (running && slot < SLOTS && !(cmd_q[slot].read_port_select_n
				&& cmd_q[slot].write_port_select_n)) c = cmd_q[slot];
		cmd_out <= c;
		wr_out  <= (running && slot < SLOTS && wd_v[slot]) ? wd_q[slot] : ~wr_out;
		if (running) slot <= slot + 1;
	end

endmodule : bds_ctrl_model

// >>> tb/test_bds_sram_port.sv
`timescale 1ns/1ps
`define CHK(what, expv, gotv) begin \
	samples_checked++; \
	if ((gotv) !== (expv)) begin \
		n_mismatch++; \
		$display("unexpected %s: expected %h, seen %h", what, expv, gotv); \
	end \
end

module test_bds_sram_port;
	logic                clk_sys_in = 1'b0;
	logic                sys_rst_in = 1'b1;
	logic                org_x18_in = 1'b0;
	bds_pkg::bds_cmd_s   cmd;
	bds_pkg::bds_wdata_s wr;
	logic [35:0]         dq_out;
	logic                dq_oe_out;
	logic                k_phase_out;
	int                  n_mismatch      = 0;
	int                  samples_checked = 0;
	logic [35:0]         mem    [256];
	logic [35:0]         exp_dq [40];
	logic                exp_oe [40];

	// Clock never stops; standby is not exercised
	always #2.5 clk_sys_in = ~clk_sys_in;

	bds_sram_port u_bds_sram_port (
		.clk_sys_in  (clk_sys_in),
		.sys_rst_in  (sys_rst_in),
		.org_x18_in  (org_x18_in),
		.cmd_in      (cmd),
		.wr_in       (wr),
		.dq_out      (dq_out),
		.dq_oe_out   (dq_oe_out),
		.k_phase_out (k_phase_out)
	);

	bds_ctrl_model u_bds_ctrl_model (
		.clk_in  (clk_sys_in),
		.cmd_out (cmd),
		.wr_out  (wr)
	);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic results();
		$display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : results

	// Each lane gets a different value so swapped lanes show up
	function automatic logic [35:0] pat(input logic [8:0] b, input int i);
		for (int l = 0; l < 4; l++) pat[l*9+:9] = b + 9'(l * 16 + i);
	endfunction : pat

	task automatic prep();
		u_bds_ctrl_model.clear();
		for (int i = 0; i < 40; i++) begin
			exp_oe[i] = 1'b0;
			exp_dq[i] = 36'h0;
		end
	endtask : prep

	task automatic wr_burst(input int s, input logic [7:0] a, input logic [15:0] m,
			input logic [8:0] b);
		logic [35:0] w;
		logic [3:0]  bw;
		u_bds_ctrl_model.post_cmd(s, 1'b0, a);
		for (int i = 0; i < 4; i++) begin
			w  = pat(b, i);
			bw = m[i*4+:4];
			u_bds_ctrl_model.post_wd(s + 2 + i, bw, w);
			for (int l = 0; l < 4; l++)
				if (!bw[l] && (l < 2 || !org_x18_in)) mem[8'(a + i)][l*9+:9] = w[l*9+:9];
		end
	endtask : wr_burst

	task automatic rd_burst(input int s, input logic [7:0] a);
		u_bds_ctrl_model.post_cmd(s, 1'b1, a);
		for (int i = 0; i < 4; i++) begin
			exp_oe[s + 4 + i] = 1'b1;
			exp_dq[s + 4 + i] = mem[8'(a + i)];
		end
	endtask : rd_burst

	task automatic run(input string name);
		int tries;
		tries = 0;
		do begin
			@(posedge clk_sys_in);
			#1;
			tries++;
		end while (k_phase_out !== 1'b0 && tries < 4);
		if (k_phase_out !== 1'b0) begin
			n_mismatch++;
			results();
		end
		u_bds_ctrl_model.slot    = 0;
		u_bds_ctrl_model.running = 1'b1;
		for (int k = 0; k < 40; k++) begin
			@(negedge clk_sys_in);
			`CHK("k_phase_out", 1'(k), k_phase_out);
			`CHK("dq_oe_out", exp_oe[k], dq_oe_out);
			`CHK("dq_out", exp_dq[k], dq_out);
		end
		@(posedge clk_sys_in);
		u_bds_ctrl_model.running = 1'b0;
		$display("test %s done", name);
	endtask : run

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		repeat (4) @(negedge clk_sys_in);
		sys_rst_in = 1'b0;
		`CHK("dq_oe_out", 1'b0, dq_oe_out);
		`CHK("dq_out", 36'h0, dq_out);
		`CHK("k_phase_out", 1'b0, k_phase_out);
		$display("test reset done");
	endtask : t_reset

	// Back-to-back reads, full and single-lane writes, all-lanes-off word.
	// A read and a write on one rise share the address; the read sees old data
	task automatic t_x36();
		prep();
		wr_burst(0, 8'h3d, 16'h0000, 9'h011);
		rd_burst(4, 8'h50);
		wr_burst(4, 8'h50, 16'h0000, 9'h0a5);
		rd_burst(8, 8'h3d);
		rd_burst(12, 8'h50);
		wr_burst(12, 8'h50, 16'hfde0, 9'h122);
		wr_burst(16, 8'h3d, 16'h07bf, 9'h1c3);
		rd_burst(22, 8'h3d);
		rd_burst(26, 8'h50);
		run("x36");
	endtask : t_x36

	// Repeated and off-phase selects must start nothing
	task automatic t_refuse();
		prep();
		rd_burst(0, 8'h60);
		u_bds_ctrl_model.post_cmd(1, 1'b1, 8'h40);
		u_bds_ctrl_model.post_cmd(2, 1'b1, 8'h3d);
		wr_burst(0, 8'h60, 16'h5000, 9'h155);
		u_bds_ctrl_model.post_cmd(2, 1'b0, 8'h60);
		rd_burst(8, 8'h60);
		rd_burst(12, 8'h20);
		run("refuse");
	endtask : t_refuse

	task automatic t_x18();
		prep();
		@(negedge clk_sys_in);
		org_x18_in = 1'b1;
		wr_burst(0, 8'h50, 16'hfde0, 9'h0f0);
		rd_burst(6, 8'h50);
		run("x18");
	endtask : t_x18

	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 36'h0;
		t_reset();
		t_x36();
		t_refuse();
		t_x18();
		results();
	end

endmodule : test_bds_sram_port
